// ### emulator_trace_profiler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module emulator_trace_profiler_tb;
   logic                clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]          paddr = 8'h00;
   logic [31:0]         pwdata = 32'h0, prdata, rd, p0;
   logic                pready, pslverr, rt = 1'b0, rs = 1'b0, fh = 1'b0, irq_b = 1'b0;
   etp_pkg::etp_state_t mst = etp_pkg::ETP_ST_IDLE;
   etp_pkg::etp_core_t  core = '0;
   etp_pkg::etp_instr_t instr = '0;
   logic                brk_pin, brk_req = 1'b0, sync_n, ebrk, fbrk, obrk;
   logic [3:0]          probe, nib = 4'h0;
   int                  low_cnt, c, mismatches = 0, check_count = 0;
   always #2.5 clk = ~clk;
   etp_trace_profiler DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
      .prdata_o(prdata), .pslverr_o(pslverr), .realtime_i(rt), .run_start_i(rs),
      .mstate_i(mst), .first_half_i(fh), .core_i(core), .instr_i(instr),
      .probe_break_in_i(brk_pin), .external_trace_inputs_i(probe), .sync_marker_n_o(sync_n),
      .ext_break_o(ebrk), .full_break_o(fbrk), .ovf_break_o(obrk));
   etp_probe_model partner (.clk_i(clk), .sync_marker_n_i(sync_n), .brk_req_i(brk_req),
      .nib_i(nib), .break_pin_o(brk_pin), .probe_o(probe), .low_cnt_o(low_cnt));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      rd = prdata;
      psel <= 1'b0; pen <= 1'b0;
   endtask
   task automatic map(input logic [15:0] a, input logic [31:0] b);
      apb(etp_pkg::OFF_MAPADR, 1'b1, {16'h0, a});
      apb(etp_pkg::OFF_MAPDAT, 1'b1, b);
   endtask
   // one instruction: s1, s2, s3 of two clocks each, first half high in the first clock of s1 and of s2
   task automatic ex(input logic [15:0] a, input logic [1:0] mc, input logic two, input logic fw);
      @(posedge clk);
      core.execution_location <= a;
      instr <= {fw, 1'b0, two, irq_b, mc};
      mst <= etp_pkg::ETP_ST_S1; fh <= 1'b1;
      @(posedge clk); fh <= 1'b0;
      @(posedge clk); mst <= etp_pkg::ETP_ST_S2; fh <= 1'b1;
      @(posedge clk); fh <= 1'b0;
      @(posedge clk); mst <= etp_pkg::ETP_ST_S3;
      repeat (2) @(posedge clk);
      mst <= etp_pkg::ETP_ST_IDLE;
   endtask
   task automatic run_start;
      @(posedge clk); rs <= 1'b1;
      @(posedge clk); rs <= 1'b0;
   endtask
   task automatic t_reset;
      apb(etp_pkg::OFF_CTRL, 1'b0, 32'h0); chk(rd, etp_pkg::CTRL_RESET);
      apb(8'h3C, 1'b0, 32'h0); chk(rd, 32'h0);
      chk({31'h0, sync_n}, 32'h1); chk({31'h0, ebrk}, 32'h0);
      chk({29'h0, fbrk, obrk, pslverr}, 32'h0);
   endtask
   task automatic t_free;
      for (int a = 16'h10; a < 16'h13; a++) map(a[15:0], 32'h0);
      apb(etp_pkg::OFF_CTRL, 1'b1, 32'h0000_0405);
      apb(etp_pkg::OFF_PTR, 1'b0, 32'h0); p0 = rd;
      ex(16'h0010, 2'h2, 1'b0, 1'b1); ex(16'h0011, 2'h3, 1'b1, 1'b1);
      rt <= 1'b0; ex(16'h0012, 2'h1, 1'b0, 1'b1); rt <= 1'b1;
      apb(etp_pkg::OFF_PTR, 1'b0, 32'h0); chk(rd, (p0 + 3) & 32'h1FFF);
      apb(etp_pkg::OFF_CYCLES, 1'b0, 32'h0); chk(rd, 32'h5);
      map(16'h0011, 32'h0); map(16'h0011, 32'h0);
      apb(etp_pkg::OFF_MAPADR, 1'b1, 32'h0012); apb(etp_pkg::OFF_MAPDAT, 1'b0, 32'h0);
      chk(rd & 32'h2, 32'h0);
      apb(etp_pkg::OFF_MAPADR, 1'b1, 32'h0010); apb(etp_pkg::OFF_MAPDAT, 1'b0, 32'h0);
      chk(rd & 32'h2, 32'h2);
   endtask
   task automatic t_limit;
      map(16'h0020, 32'h1); map(16'h0021, 32'h0);
      apb(etp_pkg::OFF_CTRL, 1'b1, 32'h0000_0011);
      apb(etp_pkg::OFF_PTR, 1'b0, 32'h0); p0 = rd;
      ex(16'h0020, 2'h1, 1'b0, 1'b1); ex(16'h0021, 2'h1, 1'b0, 1'b1);
      apb(etp_pkg::OFF_PTR, 1'b0, 32'h0); chk(rd, (p0 + 1) & 32'h1FFF);
   endtask
   task automatic t_trig;
      apb(etp_pkg::OFF_START, 1'b1, 32'h0100); apb(etp_pkg::OFF_STOP, 1'b1, 32'h0103);
      apb(etp_pkg::OFF_CTRL, 1'b1, 32'h0000_046A); run_start;
      apb(etp_pkg::OFF_PTR, 1'b0, 32'h0); p0 = rd;
      ex(16'h0100, 2'h1, 1'b0, 1'b0); ex(16'h00FF, 2'h1, 1'b0, 1'b1);
      for (int a = 16'h100; a < 16'h105; a++) ex(a[15:0], 2'h1, 1'b0, 1'b1);
      apb(etp_pkg::OFF_PTR, 1'b0, 32'h0); chk(rd, (p0 + 3) & 32'h1FFF);
      apb(etp_pkg::OFF_CYCLES, 1'b0, 32'h0); chk(rd, 32'h3);
   endtask
   task automatic t_probe;
      apb(etp_pkg::OFF_CTRL, 1'b1, 32'h0000_0001);
      nib <= 4'hA; irq_b <= 1'b1;
      repeat (4) @(posedge clk);
      ex(16'h0030, 2'h1, 1'b0, 1'b1); irq_b <= 1'b0;
      apb(etp_pkg::OFF_PTR, 1'b0, 32'h0);
      apb(etp_pkg::OFF_TRIDX, 1'b1, (rd - 1) & 32'h1FFF);
      repeat (2) @(posedge clk);
      apb(etp_pkg::OFF_TRDAT0, 1'b0, 32'h0); chk(rd & 32'h3F, 32'h2A);
   endtask
   task automatic t_sync;
      map(16'h0040, 32'h4); map(16'h0041, 32'h0); map(16'h0042, 32'h4);
      c = low_cnt; ex(16'h0040, 2'h1, 1'b0, 1'b1); chk({31'h0, low_cnt > c}, 32'h1);
      c = low_cnt; ex(16'h0041, 2'h1, 1'b0, 1'b1); chk(low_cnt, c);
      ex(16'h0042, 2'h1, 1'b0, 1'b0); chk(low_cnt, c);
   endtask
   // 4096 two-entry instructions, one s1 every two clocks: the pointer wraps exactly once
   task automatic t_full;
      apb(etp_pkg::OFF_CTRL, 1'b1, 32'h0000_0101); run_start;
      core.execution_location <= 16'h0060;
      instr <= {1'b1, 1'b0, 1'b1, 1'b0, 2'h1};
      for (int i = 0; i < 4096; i++) begin
         @(posedge clk); mst <= etp_pkg::ETP_ST_S1;
         @(posedge clk); mst <= etp_pkg::ETP_ST_S3;
      end
      @(posedge clk); mst <= etp_pkg::ETP_ST_IDLE;
      repeat (2) @(posedge clk);
      chk({31'h0, fbrk}, 32'h1);
      run_start; repeat (2) @(posedge clk); chk({31'h0, fbrk}, 32'h0);
   endtask
   task automatic t_brk(input logic en, input logic exp);
      apb(etp_pkg::OFF_CTRL, 1'b1, {24'h0, en, 7'h01}); run_start;
      brk_req <= 1'b1; repeat (4) @(posedge clk);
      ex(16'h0050, 2'h1, 1'b0, 1'b1); brk_req <= 1'b0;
      repeat (2) @(posedge clk);
      chk({31'h0, ebrk}, {31'h0, exp});
      run_start; repeat (2) @(posedge clk); chk({31'h0, ebrk}, 32'h0);
   endtask
   initial begin
      #200000;
      mismatches++;
      wrap_up;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1; rt <= 1'b1;
      t_reset; t_free; t_limit; t_trig; t_probe; t_sync; t_full;
      t_brk(1'b0, 1'b0); t_brk(1'b1, 1'b1);
      wrap_up;
   end
endmodule
`default_nettype wire

// ### etp_pkg.sv
package etp_pkg;

   localparam int ADDR_W    = 16;
   localparam int PTR_W     = 13;
   localparam int CNT_W     = 24;
   localparam int PROBE_W   = 4;
   localparam int MCYC_W    = 2;

   // apb register byte offsets
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_START   = 8'h04;
   localparam logic [7:0] OFF_STOP    = 8'h08;
   localparam logic [7:0] OFF_PTR     = 8'h0C;
   localparam logic [7:0] OFF_CYCLES  = 8'h10;
   localparam logic [7:0] OFF_STATUS  = 8'h14;
   localparam logic [7:0] OFF_MAPADR  = 8'h18;
   localparam logic [7:0] OFF_MAPDAT  = 8'h1C;
   localparam logic [7:0] OFF_TRIDX   = 8'h20;
   localparam logic [7:0] OFF_TRDAT0  = 8'h24;
   localparam logic [7:0] OFF_TRDAT1  = 8'h28;
   localparam logic [7:0] OFF_TRDAT2  = 8'h2C;

   // ctrl field positions
   localparam int CTRL_TMODE_LSB = 0;
   localparam int CTRL_CMODE_LSB = 2;
   localparam int CTRL_TLIMIT    = 4;
   localparam int CTRL_START_EN  = 5;
   localparam int CTRL_STOP_EN   = 6;
   localparam int CTRL_EXTBRK_EN = 7;
   localparam int CTRL_FULL_EN   = 8;
   localparam int CTRL_OVF_EN    = 9;
   localparam int CTRL_CNT_CLR   = 10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // map data bit positions
   localparam int MAP_TEN  = 0;
   localparam int MAP_EXEC = 1;
   localparam int MAP_SYNC = 2;

   typedef enum logic [1:0] {
      ETP_MODE_OFF  = 2'h0,
      ETP_MODE_FREE = 2'h1,
      ETP_MODE_TRIG = 2'h2
   } etp_mode_t;

   // machine state of the evaluation core, gray along s1 -> s2 -> s3
   typedef enum logic [1:0] {
      ETP_ST_IDLE = 2'h0,
      ETP_ST_S1   = 2'h1,
      ETP_ST_S2   = 2'h3,
      ETP_ST_S3   = 2'h2
   } etp_state_t;

   // core status presented at the instruction boundary
   typedef struct packed {
      logic [15:0] execution_location;
      logic [3:0]  working_register;
      logic [11:0] ram_access_location;
      logic [3:0]  ram_value;
      logic [2:0]  condition_flags;
      logic        master_irq_enable;
      logic        melody_request;
      logic [3:0]  current_bank;
      logic [3:0]  extra_bank;
      logic [7:0]  primary_pointer_pair;
      logic [7:0]  index_pair;
      logic [4:0]  call_stack_pointer;
      logic [3:0]  register_stack_pointer;
   } etp_core_t;

   // core flags describing the instruction about to run
   typedef struct packed {
      logic       first_word;
      logic       ram_write;
      logic       two_entry;
      logic       irq_req;
      logic [1:0] mcycles;
   } etp_instr_t;

   typedef struct packed {
      etp_core_t         core;
      logic              irq_req;
      logic              second_half;
      logic [3:0]        probe_trace_nibble;
   } etp_entry_t;

   localparam int ENTRY_W = $bits(etp_entry_t);

endpackage

// ### etp_probe_model.sv
`timescale 1ns/1ps
`default_nettype none
// target board side of the probe cable: break pin, trace nibble, sync monitor
module etp_probe_model (
   input  wire logic       clk_i,
   input  wire logic       sync_marker_n_i,
   input  wire logic       brk_req_i,
   input  wire logic [3:0] nib_i,
   output logic            break_pin_o,
   output logic [3:0]      probe_o,
   output int              low_cnt_o
);
   int low_cnt = 0;
   assign low_cnt_o = low_cnt;
   // pins change only after a clock edge, like a board synchronous to the core
   always @(posedge clk_i) begin
      break_pin_o <= brk_req_i;
      probe_o     <= nib_i;
      if (sync_marker_n_i === 1'b0) begin
         low_cnt <= low_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// ### etp_trace_profiler.sv
// Summary of operation
// - 13-bit wrapping write pointer into an 8192-entry trace table
// - each entry holds core registers, flags, pointers, stacks and probe bits
// - interrupt requests are recorded in the trace entry too
// - per-address trace enable bits limit tracing when the option is on
// - trace modes off, free-running and triggered; limit combines with both
// - start begins, stop ends; start-only runs to break; stop-only starts at run
// - triggers act before execution: start recorded, stop not
// - triggers match only first instruction words
// - trace enable bits honoured only at first words
// - trace records only in real-time emulation, never when stepping
// - ram fields update only on data memory writes, else repeat
// - flag changes land in the entry of the following instruction
// - external memory and rom table instructions take two entries
// - executed bit per address set on real-time access, not stepping
// - 24-bit machine cycle counter with off, free and triggered modes
// - counter triggers like trace: start counted, stop not
// - counter advances only in real-time emulation
// - rising edge on probe break input raises break when enabled
// - external break registered at start of second machine state
// - sync bit drives marker low for first half of first machine state
// - sync bits honoured only at first words
// - probe inputs latched at start of first machine state into entry
// - pointer wrap in real time raises break when enabled; run clears
// - counter overflow in real time raises break when enabled; run clears
`timescale 1ns/1ps
`default_nettype none
module etp_trace_profiler #(
   parameter int DEPTH  = 8192,
   parameter int CODE_N = 65536
) (
   input  wire logic                ref_clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [7:0]          paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic                     pready_o,
   output logic [31:0]              prdata_o,
   output logic                     pslverr_o,
   input  wire logic                realtime_i,
   input  wire logic                run_start_i,
   input  wire etp_pkg::etp_state_t mstate_i,
   input  wire logic                first_half_i,
   input  wire etp_pkg::etp_core_t  core_i,
   input  wire etp_pkg::etp_instr_t instr_i,
   input  wire logic                probe_break_in_i,
   input  wire logic [3:0]          external_trace_inputs_i,
   output logic                     sync_marker_n_o,
   output logic                     ext_break_o,
   output logic                     full_break_o,
   output logic                     ovf_break_o
);
   // the pointer and map widths are fixed by the package, so only these sizes fit
   if (DEPTH != (1 << etp_pkg::PTR_W) || CODE_N != (1 << etp_pkg::ADDR_W)) begin : g_bad_size
      $error("etp_trace_profiler: unsupported DEPTH or CODE_N");
   end

   logic [31:0]                        ctrl_reg;
   logic [15:0]                        start_reg;
   logic [15:0]                        stop_reg;
   logic [15:0]                        map_adr_reg;
   logic [12:0]                        tr_idx_reg;
   logic [12:0]                        ptr_reg;
   logic [23:0]                        cnt_reg;
   logic                               armed_reg;
   logic                               second_reg;
   logic [3:0]                         probe_reg;
   logic [11:0]                        ram_loc_reg;
   logic [3:0]                         ram_val_reg;
   logic                               ext_s1_reg;
   logic                               ext_s2_reg;
   logic                               ext_prev_reg;
   logic                               ext_pend_reg;
   logic                               ext_break_reg;
   logic                               full_break_reg;
   logic                               ovf_break_reg;
   logic [3:0]                         pr_s1_reg;
   logic [3:0]                         pr_s2_reg;
   logic                               sync_reg;
   logic [31:0]                        prdata_reg;
   logic [2:0]                         map_mem [CODE_N];
   logic [etp_pkg::ENTRY_W-1:0]        tr_mem  [DEPTH];
   logic [etp_pkg::ENTRY_W-1:0]        tr_rd;
   etp_pkg::etp_state_t                st_prev_reg;
   etp_pkg::etp_core_t                 flags_prev_reg;
   etp_pkg::etp_entry_t                entry;

   etp_pkg::etp_mode_t tmode;
   etp_pkg::etp_mode_t cmode;
   logic               wr_en;
   logic               rd_en;
   logic               s1_start;
   logic               s2_start;
   logic [15:0]        pc;
   logic [2:0]         map_cur;
   logic               is_start;
   logic               is_stop;
   logic               win_next;
   logic               in_win;
   logic               do_trace;
   logic               do_count;
   logic [24:0]        cnt_sum;

   function automatic logic [31:0] pad16(input logic [15:0] v);
      pad16 = {16'h0000, v};
   endfunction

   assign tmode    = etp_pkg::etp_mode_t'(ctrl_reg[etp_pkg::CTRL_TMODE_LSB +: 2]);
   assign cmode    = etp_pkg::etp_mode_t'(ctrl_reg[etp_pkg::CTRL_CMODE_LSB +: 2]);
   assign wr_en    = psel_i && penable_i && pwrite_i;
   assign rd_en    = psel_i && !penable_i && !pwrite_i;
   assign s1_start = (mstate_i == etp_pkg::ETP_ST_S1) && (st_prev_reg != etp_pkg::ETP_ST_S1);
   assign s2_start = (mstate_i == etp_pkg::ETP_ST_S2) && (st_prev_reg != etp_pkg::ETP_ST_S2);
   assign pc       = core_i.execution_location;
   assign map_cur  = map_mem[pc];

   // triggers act before execution and only on first words
   assign is_start = ctrl_reg[etp_pkg::CTRL_START_EN] && instr_i.first_word
                     && (pc == start_reg);
   assign is_stop  = ctrl_reg[etp_pkg::CTRL_STOP_EN] && instr_i.first_word
                     && (pc == stop_reg);
   assign win_next = is_stop ? 1'b0 : (is_start ? 1'b1 : armed_reg);
   assign in_win   = win_next;

   always_comb begin
      do_trace = 1'b0;
      if (realtime_i && s1_start) begin
         if (tmode == etp_pkg::ETP_MODE_FREE)
            do_trace = 1'b1;
         else if (tmode == etp_pkg::ETP_MODE_TRIG)
            do_trace = in_win;
         if (ctrl_reg[etp_pkg::CTRL_TLIMIT] && instr_i.first_word
             && !map_cur[etp_pkg::MAP_TEN])
            do_trace = 1'b0;
      end
   end

   always_comb begin
      do_count = 1'b0;
      if (realtime_i && s1_start) begin
         if (cmode == etp_pkg::ETP_MODE_FREE)
            do_count = 1'b1;
         else if (cmode == etp_pkg::ETP_MODE_TRIG)
            do_count = in_win;
      end
   end

   assign cnt_sum = {1'b0, cnt_reg} + {23'h000000, instr_i.mcycles};

   always_comb begin
      entry                    = '0;
      entry.core               = core_i;
      entry.core.condition_flags   = flags_prev_reg.condition_flags;
      entry.core.master_irq_enable = flags_prev_reg.master_irq_enable;
      entry.core.ram_access_location = instr_i.ram_write ?
                                        core_i.ram_access_location : ram_loc_reg;
      entry.core.ram_value     = instr_i.ram_write ? core_i.ram_value : ram_val_reg;
      entry.irq_req            = instr_i.irq_req;
      entry.second_half        = second_reg;
      // first entry takes the nibble seen at s1 entry, the second one its latched copy
      entry.probe_trace_nibble = second_reg ? pr_s2_reg : probe_reg;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i)
         st_prev_reg <= etp_pkg::ETP_ST_IDLE;
      else
         st_prev_reg <= mstate_i;
   end

   // apb register writes
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ctrl_reg    <= etp_pkg::CTRL_RESET;
         start_reg   <= 16'h0000;
         stop_reg    <= 16'h0000;
         map_adr_reg <= 16'h0000;
         tr_idx_reg  <= 13'h0000;
      end else if (wr_en) begin
         if (paddr_i == etp_pkg::OFF_CTRL)
            ctrl_reg <= pwdata_i;
         else if (paddr_i == etp_pkg::OFF_START)
            start_reg <= pwdata_i[15:0];
         else if (paddr_i == etp_pkg::OFF_STOP)
            stop_reg <= pwdata_i[15:0];
         else if (paddr_i == etp_pkg::OFF_MAPADR)
            map_adr_reg <= pwdata_i[15:0];
         else if (paddr_i == etp_pkg::OFF_TRIDX)
            tr_idx_reg <= pwdata_i[12:0];
      end
   end

   // map bits: trace enable, executed, sync; software write vs core set
   always_ff @(posedge ref_clk_i) begin
      if (wr_en && paddr_i == etp_pkg::OFF_MAPDAT)
         map_mem[map_adr_reg] <= pwdata_i[2:0];
      else if (realtime_i && s1_start)
         map_mem[pc][etp_pkg::MAP_EXEC] <= 1'b1;
   end

   // trace window, pointer and ram capture
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         armed_reg   <= 1'b0;
         ptr_reg     <= 13'h0000;
         second_reg  <= 1'b0;
         ram_loc_reg <= 12'h000;
         ram_val_reg <= 4'h0;
         flags_prev_reg <= '0;
      end else begin
         if (run_start_i)
            armed_reg <= !ctrl_reg[etp_pkg::CTRL_START_EN];
         else if (realtime_i && s1_start)
            armed_reg <= win_next;
         if (realtime_i && s1_start) begin
            flags_prev_reg <= core_i;
            if (instr_i.ram_write) begin
               ram_loc_reg <= core_i.ram_access_location;
               ram_val_reg <= core_i.ram_value;
            end
         end
         if (do_trace || second_reg) begin
            ptr_reg    <= ptr_reg + 13'h0001;
            second_reg <= do_trace && instr_i.two_entry;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (do_trace || second_reg)
         tr_mem[ptr_reg] <= entry;
      tr_rd <= tr_mem[tr_idx_reg];
   end

   // cycle counter
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i)
         cnt_reg <= 24'h000000;
      else if (wr_en && paddr_i == etp_pkg::OFF_CTRL && pwdata_i[etp_pkg::CTRL_CNT_CLR])
         cnt_reg <= 24'h000000;
      else if (do_count)
         cnt_reg <= cnt_sum[23:0];
   end

   // probe synchronisers and latches
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ext_s1_reg   <= 1'b0;
         ext_s2_reg   <= 1'b0;
         pr_s1_reg    <= 4'h0;
         probe_reg    <= 4'h0;
         pr_s2_reg    <= 4'h0;
      end else begin
         ext_s1_reg <= probe_break_in_i;
         ext_s2_reg <= ext_s1_reg;
         pr_s1_reg  <= external_trace_inputs_i;
         probe_reg  <= pr_s1_reg;
         if (s1_start)
            pr_s2_reg <= probe_reg;
      end
   end

   // break requests
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ext_prev_reg   <= 1'b0;
         ext_pend_reg   <= 1'b0;
         ext_break_reg  <= 1'b0;
         full_break_reg <= 1'b0;
         ovf_break_reg  <= 1'b0;
      end else begin
         ext_prev_reg <= ext_s2_reg;
         // a new edge wins over the resume clear in the same cycle
         if (realtime_i && ctrl_reg[etp_pkg::CTRL_EXTBRK_EN]
             && ext_s2_reg && !ext_prev_reg)
            ext_pend_reg <= 1'b1;
         else if (run_start_i)
            ext_pend_reg <= 1'b0;
         if (s2_start && ext_pend_reg)
            ext_break_reg <= 1'b1;
         else if (run_start_i)
            ext_break_reg <= 1'b0;
         if ((do_trace || second_reg) && ptr_reg == 13'h1FFF
             && ctrl_reg[etp_pkg::CTRL_FULL_EN])
            full_break_reg <= 1'b1;
         else if (run_start_i)
            full_break_reg <= 1'b0;
         if (do_count && cnt_sum[24] && ctrl_reg[etp_pkg::CTRL_OVF_EN])
            ovf_break_reg <= 1'b1;
         else if (run_start_i)
            ovf_break_reg <= 1'b0;
      end
   end

   // sync marker: low from the s1 entry itself, held by sync_reg for the rest of the half
   logic sync_hit;
   assign sync_hit = instr_i.first_word && map_cur[etp_pkg::MAP_SYNC] && realtime_i;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i)
         sync_reg <= 1'b0;
      else if (s1_start)
         sync_reg <= sync_hit;
      else if (!(mstate_i == etp_pkg::ETP_ST_S1 && first_half_i))
         sync_reg <= 1'b0;
   end
   assign sync_marker_n_o = !(((s1_start && sync_hit) || sync_reg)
                              && mstate_i == etp_pkg::ETP_ST_S1 && first_half_i);

   // apb read data, registered in setup phase
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i)
         prdata_reg <= 32'h0000_0000;
      else if (rd_en) begin
         if (paddr_i == etp_pkg::OFF_CTRL)
            prdata_reg <= ctrl_reg;
         else if (paddr_i == etp_pkg::OFF_START)
            prdata_reg <= pad16(start_reg);
         else if (paddr_i == etp_pkg::OFF_STOP)
            prdata_reg <= pad16(stop_reg);
         else if (paddr_i == etp_pkg::OFF_PTR)
            prdata_reg <= pad16({3'h0, ptr_reg});
         else if (paddr_i == etp_pkg::OFF_CYCLES)
            prdata_reg <= {8'h00, cnt_reg};
         else if (paddr_i == etp_pkg::OFF_STATUS)
            prdata_reg <= {27'h0000000, armed_reg, ovf_break_reg,
                           full_break_reg, ext_break_reg, ext_pend_reg};
         else if (paddr_i == etp_pkg::OFF_MAPADR)
            prdata_reg <= pad16(map_adr_reg);
         else if (paddr_i == etp_pkg::OFF_MAPDAT)
            prdata_reg <= {29'h0000000, map_mem[map_adr_reg]};
         else if (paddr_i == etp_pkg::OFF_TRIDX)
            prdata_reg <= pad16({3'h0, tr_idx_reg});
         else if (paddr_i == etp_pkg::OFF_TRDAT0)
            prdata_reg <= tr_rd[31:0];
         else if (paddr_i == etp_pkg::OFF_TRDAT1)
            prdata_reg <= tr_rd[63:32];
         else if (paddr_i == etp_pkg::OFF_TRDAT2)
            prdata_reg <= {{(96 - etp_pkg::ENTRY_W){1'b0}}, tr_rd[etp_pkg::ENTRY_W-1:64]};
         else
            prdata_reg <= 32'h0000_0000;
      end
   end

   assign pready_o     = 1'b1;
   assign pslverr_o    = 1'b0;
   assign prdata_o     = prdata_reg;
   assign ext_break_o  = ext_break_reg;
   assign full_break_o = full_break_reg;
   assign ovf_break_o  = ovf_break_reg;

   a_ptr_advance: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      do_trace |=> ptr_reg == $past(ptr_reg) + 13'h0001)
      else $error("trace pointer did not advance");
   a_step_no_trace: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !realtime_i |-> !do_trace && !do_count)
      else $error("recording while stepping");
   a_cnt_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (!realtime_i && !wr_en) |=> $stable(cnt_reg))
      else $error("counter moved while stepping");
   a_stop_blocks: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (is_stop && tmode == etp_pkg::ETP_MODE_TRIG) |-> !do_trace)
      else $error("stop instruction traced");
   a_two_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (do_trace && instr_i.two_entry) |=> second_reg)
      else $error("second entry missing");
   a_limit_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ctrl_reg[etp_pkg::CTRL_TLIMIT] && instr_i.first_word
       && !map_cur[etp_pkg::MAP_TEN]) |-> !do_trace)
      else $error("limited address traced");
   a_full_break: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (do_trace && ptr_reg == 13'h1FFF && ctrl_reg[etp_pkg::CTRL_FULL_EN]) |=> full_break_o)
      else $error("wrap did not break");
   a_ovf_break: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (do_count && cnt_sum[24] && ctrl_reg[etp_pkg::CTRL_OVF_EN]) |=> ovf_break_o)
      else $error("overflow did not break");
endmodule
`default_nettype wire
